// ===== logic/ssm_pkg.sv
/*
 * Package for the serial memory slave: opcodes, status bit positions,
 * reset values and array geometry.
 * Assumes a single system clock domain that oversamples the serial pins.
 */
`default_nettype none
package ssm_pkg;
	localparam int          SSM_ADDR_W      = 17;
	localparam int          SSM_DEPTH       = 131072;
	localparam logic [7:0]  SSM_OP_SET_WE   = 8'h06;
	localparam logic [7:0]  SSM_OP_CLR_WE   = 8'h04;
	localparam logic [7:0]  SSM_OP_STAT_RD  = 8'h05;
	localparam logic [7:0]  SSM_OP_STAT_WR  = 8'h01;
	localparam logic [7:0]  SSM_OP_MEM_RD   = 8'h03;
	localparam logic [7:0]  SSM_OP_MEM_WR   = 8'h02;
	localparam logic [7:0]  SSM_OP_SLEEP    = 8'hb9;
	localparam logic [7:0]  SSM_OP_WAKE     = 8'hab;
	localparam int          SSM_SR_SWD      = 7;
	localparam int          SSM_SR_BPH      = 3;
	localparam int          SSM_SR_BPL      = 2;
	localparam int          SSM_SR_WEL      = 1;
	localparam logic [7:0]  SSM_SR_RST      = 8'h00;
	localparam logic [7:0]  SSM_SR_USER_MSK = 8'h71;
	localparam int          SSM_ADDR_BYTES  = 3;
	typedef enum logic [2:0] {
		SSM_ST_OP, SSM_ST_ADDR, SSM_ST_MRD, SSM_ST_MWR, SSM_ST_SRD, SSM_ST_SWR, SSM_ST_DONE
	} ssm_state_t;
endpackage : ssm_pkg
`default_nettype wire

// ===== logic/ssm_slave.sv
/*
 * Serial peripheral memory slave with 128K x 8 array, status register,
 * write protection and sleep state.
 * Assumes serial pins are asynchronous and much slower than i_mclk.
 */
`default_nettype none
// Notes on behaviour
// [RL1] Chip select high: inputs ignored, output floated, standby asserted.
// [RL2] Output driven only while returning read data, floated while suspended.
// [RL3] Output changes only on serial clock falling edges.
// [RL4] Serial input sampled on rising edges only.
// [RL5] Clock idle level at chip select fall selects mode 0 or 3.
// [RL6] Fully static; clock may stop without losing state.
// [RL7] Host keeps serial clock at or below 40 MHz.
// [RL8] Suspend low freezes transaction, ignores chip select and clock.
// [RL9] Host changes suspend only while chip select low.
// [RL10] Write-protect low refuses status writes.
// [RL11] Transaction starts on chip select fall; first byte is opcode.
// [RL12] One command per chip select low period.
// [RL13] Host ends transactions on byte boundaries.
// [RL14] 06h sets, 04h clears write enable; no address or data.
// [RL15] 03h read, 02h write; three address bytes then data stream.
// [RL16] 05h returns status byte, 01h writes status byte.
// [RL17] B9h enters sleep, ABh leaves sleep.
// [RL18] Array holds 131072 bytes, no write delay.
// [RL19] Low 17 address bits used; address increments and wraps to zero.
// [RL20] Memory and status writes need write enable latch set.
// [RL21] Block-protect bits guard none, upper quarter, upper half, all.
// [RL22] With disable bit set, protection bits change only while write-protect high.
// [RL23] All bytes shifted most significant bit first.
// [RL24] Partial bytes at chip select rise are discarded.
module ssm_slave
	import ssm_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	input  wire logic i_cs_n,
	input  wire logic i_sck,
	input  wire logic i_si,
	input  wire logic i_hold_n,
	input  wire logic i_wp_n,
	output logic      o_so,
	output logic      o_so_oe,
	output logic      o_standby,
	output logic      o_sleep
);
	import ssm_pkg::*;

	// ==========================================================
	// Pin synchronisers
	// Two flops per pin; only the second flop feeds any logic
	logic [1:0] cs_s_r, cs_s_nxt;
	logic [1:0] sck_s_r, sck_s_nxt;
	logic [1:0] si_s_r, si_s_nxt;
	logic [1:0] hold_s_r, hold_s_nxt;
	logic [1:0] wp_s_r, wp_s_nxt;
	logic       sck_d_r, sck_d_nxt;
	logic       cs_d_r, cs_d_nxt;

	logic cs_n, sck, si, hold_n, wp_n;
	assign cs_n   = cs_s_r[1];
	assign sck    = sck_s_r[1];
	assign si     = si_s_r[1];
	assign hold_n = hold_s_r[1];
	assign wp_n   = wp_s_r[1];

	always_comb begin
		cs_s_nxt   = {cs_s_r[0], i_cs_n};
		sck_s_nxt  = {sck_s_r[0], i_sck};
		si_s_nxt   = {si_s_r[0], i_si};
		hold_s_nxt = {hold_s_r[0], i_hold_n};
		wp_s_nxt   = {wp_s_r[0], i_wp_n};
		sck_d_nxt  = sck_d_r;
		cs_d_nxt   = cs_d_r;
		// Edge history frozen in suspend, so a clock or select change made during a hold shows as an edge on release
		if (hold_n) begin
			sck_d_nxt = sck; // RL8
			cs_d_nxt  = cs_n; // RL8
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cs_s_r   <= 2'h3;
			sck_s_r  <= 2'h0;
			si_s_r   <= 2'h0;
			hold_s_r <= 2'h3;
			wp_s_r   <= 2'h3;
			sck_d_r  <= 1'b0;
			cs_d_r   <= 1'b1;
		end else if (i_ce) begin
			cs_s_r   <= cs_s_nxt;
			sck_s_r  <= sck_s_nxt;
			si_s_r   <= si_s_nxt;
			hold_s_r <= hold_s_nxt;
			wp_s_r   <= wp_s_nxt;
			sck_d_r  <= sck_d_nxt;
			cs_d_r   <= cs_d_nxt;
		end
	end

	// ==========================================================
	// Storage array
	logic [7:0] mem [0:SSM_DEPTH-1]; // RL18

	// ==========================================================
	// Transaction state
	ssm_state_t              st_r, st_nxt;
	logic [7:0]              sh_r, sh_nxt;
	logic [2:0]              bit_r, bit_nxt;
	logic [1:0]              abyte_r, abyte_nxt;
	logic [SSM_ADDR_W-1:0]   addr_r, addr_nxt;
	logic [7:0]              op_r, op_nxt;
	logic [7:0]              tx_r, tx_nxt;
	logic                    so_r, so_nxt;
	logic                    drv_r, drv_nxt;
	logic [7:0]              sr_r, sr_nxt;
	logic                    sleep_r, sleep_nxt;
	logic                    act_r, act_nxt;
	logic                    mode3_r, mode3_nxt;
	logic                    sr_wr_ok;
	logic                    wr_en;
	logic [SSM_ADDR_W-1:0]   wr_addr;
	logic [7:0]              wr_data;

	logic rise, fall, live, cs_fall, cs_rise;
	assign live    = hold_n && !cs_n; // RL8
	assign rise    = live && sck && !sck_d_r; // RL4
	assign fall    = live && !sck && sck_d_r; // RL3
	assign cs_fall = hold_n && !cs_n && cs_d_r; // RL11
	assign cs_rise = hold_n && cs_n && !cs_d_r;

	// Status write needs the latch and the protect pin high
	// Protect pin low blocks every status write, disable bit or not
	assign sr_wr_ok = sr_r[SSM_SR_WEL] && wp_n; // RL10 RL22

	// Protection check for one byte address
	function automatic logic ssm_prot(input logic [7:0] sr, input logic [SSM_ADDR_W-1:0] a);
		unique case ({sr[SSM_SR_BPH], sr[SSM_SR_BPL]})
			2'b00: ssm_prot = 1'b0;
			2'b01: ssm_prot = (a[SSM_ADDR_W-1:SSM_ADDR_W-2] == 2'b11);
			2'b10: ssm_prot = a[SSM_ADDR_W-1];
			2'b11: ssm_prot = 1'b1;
		endcase // RL21
	endfunction : ssm_prot

	logic [7:0] byte_in;
	assign byte_in = {sh_r[6:0], si}; // RL23

	// Chip select edges take priority over serial clock edges
	always_comb begin
		st_nxt    = st_r;
		sh_nxt    = sh_r;
		bit_nxt   = bit_r;
		abyte_nxt = abyte_r;
		addr_nxt  = addr_r;
		op_nxt    = op_r;
		tx_nxt    = tx_r;
		so_nxt    = so_r;
		drv_nxt   = drv_r;
		sr_nxt    = sr_r;
		sleep_nxt = sleep_r;
		act_nxt   = act_r;
		mode3_nxt = mode3_r;
		wr_en     = 1'b0;
		wr_addr   = addr_r;
		wr_data   = byte_in;
		if (cs_fall) begin
			st_nxt    = SSM_ST_OP; // RL11
			bit_nxt   = 3'h0; // RL24
			abyte_nxt = 2'h0;
			act_nxt   = 1'b1;
			drv_nxt   = 1'b0;
			mode3_nxt = sck; // RL5
		end else if (cs_rise) begin
			act_nxt = 1'b0; // RL1
			drv_nxt = 1'b0; // RL2
		end else if (rise && act_r) begin
			sh_nxt  = byte_in; // RL4
			bit_nxt = bit_r + 3'h1;
			if (bit_r == 3'h7) begin
				unique case (st_r)
					SSM_ST_OP: begin
						op_nxt = byte_in;
						st_nxt = SSM_ST_DONE; // RL12
						if (byte_in == SSM_OP_SET_WE && !sleep_r) begin
							sr_nxt[SSM_SR_WEL] = 1'b1; // RL14 RL20
						end else if (byte_in == SSM_OP_CLR_WE && !sleep_r) begin
							sr_nxt[SSM_SR_WEL] = 1'b0; // RL14
						end else if (byte_in == SSM_OP_SLEEP) begin
							sleep_nxt = 1'b1; // RL17
						end else if (byte_in == SSM_OP_WAKE) begin
							sleep_nxt = 1'b0; // RL17
						end else if (sleep_r) begin
							st_nxt = SSM_ST_DONE;
						end else if (byte_in == SSM_OP_STAT_RD) begin
							st_nxt = SSM_ST_SRD; // RL16
							tx_nxt = sr_r;
						end else if (byte_in == SSM_OP_STAT_WR) begin
							st_nxt = SSM_ST_SWR; // RL16
						end else if (byte_in == SSM_OP_MEM_RD || byte_in == SSM_OP_MEM_WR) begin
							st_nxt = SSM_ST_ADDR; // RL15
						end
					end
					SSM_ST_ADDR: begin
						abyte_nxt = abyte_r + 2'h1;
						addr_nxt  = {addr_r[SSM_ADDR_W-9:0], byte_in}; // RL19
						if (abyte_r == 2'(SSM_ADDR_BYTES - 1)) begin
							if (op_r == SSM_OP_MEM_RD) begin
								st_nxt = SSM_ST_MRD;
								tx_nxt = mem[{addr_r[SSM_ADDR_W-9:0], byte_in}];
							end else begin
								st_nxt = SSM_ST_MWR;
							end
						end
					end
					SSM_ST_MWR: begin
						// Whole byte only, so a cut byte never lands
						wr_en    = sr_r[SSM_SR_WEL] && !ssm_prot(sr_r, addr_r); // RL20 RL24
						addr_nxt = addr_r + 17'h1; // RL19
					end
					SSM_ST_MRD: begin
						addr_nxt = addr_r + 17'h1; // RL19
						tx_nxt   = mem[addr_r + 17'h1];
					end
					SSM_ST_SRD: begin
						// Status repeats while clocked
						tx_nxt = sr_r;
					end
					SSM_ST_SWR: begin
						st_nxt = SSM_ST_DONE;
						if (sr_wr_ok) begin // RL10 RL22
							sr_nxt = (byte_in & ~(8'h01 << SSM_SR_WEL))
								| (sr_r & (8'h01 << SSM_SR_WEL));
						end
					end
					SSM_ST_DONE: ;
				endcase
			end
		end else if (fall && act_r && (st_r == SSM_ST_MRD || st_r == SSM_ST_SRD)) begin
			// First falling edge of a byte loads its msb
			drv_nxt = 1'b1; // RL2
			so_nxt  = tx_r[3'h7 - bit_r]; // RL3 RL23
		end
		// Clock parked high at select must not leave the output driven
		if (mode3_r && cs_fall) begin
			drv_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r    <= SSM_ST_DONE;
			sh_r    <= 8'h00;
			bit_r   <= 3'h0;
			abyte_r <= 2'h0;
			addr_r  <= 17'h0;
			op_r    <= 8'h00;
			tx_r    <= 8'h00;
			so_r    <= 1'b0;
			drv_r   <= 1'b0;
			sr_r    <= SSM_SR_RST; // RL20
			sleep_r <= 1'b0;
			act_r   <= 1'b0;
			mode3_r <= 1'b0;
		end else if (i_ce) begin // RL6
			st_r    <= st_nxt;
			sh_r    <= sh_nxt;
			bit_r   <= bit_nxt;
			abyte_r <= abyte_nxt;
			addr_r  <= addr_nxt;
			op_r    <= op_nxt;
			tx_r    <= tx_nxt;
			so_r    <= so_nxt;
			drv_r   <= drv_nxt;
			sr_r    <= sr_nxt;
			sleep_r <= sleep_nxt;
			act_r   <= act_nxt;
			mode3_r <= mode3_nxt;
		end
	end

	// Single write port, one whole byte per data byte
	always_ff @(posedge i_mclk) begin
		if (i_ce && wr_en) begin
			mem[wr_addr] <= wr_data; // RL18
		end
	end

	// ==========================================================
	// Outputs
	assign o_so      = so_r;
	assign o_so_oe   = drv_r && act_r && hold_n && !cs_n; // RL1 RL2
	assign o_standby = !act_r; // RL1
	assign o_sleep   = sleep_r;
endmodule : ssm_slave
`default_nettype wire

// ===== test/ssm_slave_chk.sv
/* Port checker for ssm_slave, bound to each instance.
   Assumes checks pause while i_ce is low. */
`default_nettype none
module ssm_slave_chk (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_hold_n,
	input wire logic o_so,
	input wire logic o_so_oe,
	input wire logic o_standby,
	input wire logic o_sleep
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====================
	// Checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst || !i_ce);
	a_desel_float: assert property (i_cs_n [*6] |-> !o_so_oe)
		else $error("driven while deselected");
	a_desel_standby: assert property (i_cs_n [*6] |-> o_standby)
		else $error("no standby");
	a_sel_active: assert property (!i_cs_n [*6] |-> !o_standby)
		else $error("standby while selected");
	a_hold_float: assert property (!i_hold_n [*6] |-> !o_so_oe)
		else $error("driven while suspended");
	a_hold_freeze: assert property (!i_hold_n [*6] |-> $stable(o_so))
		else $error("output moved in suspend");
	a_so_on_fall: assert property (o_so_oe && $changed(o_so) |-> !$past(i_sck, 2))
		else $error("output moved off a fall");
	a_oe_rise_ok: assert property ($rose(o_so_oe) |-> !i_cs_n && i_hold_n && !o_sleep)
		else $error("output enabled out of context");
	a_reset_state: assert property ($fell(i_rst) |-> !o_so_oe && o_standby && !o_sleep)
		else $error("wrong state after reset");
endmodule : ssm_slave_chk
bind ssm_slave ssm_slave_chk i_ssm_slave_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
	.i_cs_n(i_cs_n), .i_sck(i_sck), .i_hold_n(i_hold_n), .o_so(o_so),
	.o_so_oe(o_so_oe), .o_standby(o_standby), .o_sleep(o_sleep));
`default_nettype wire

// ===== test/ssm_host.sv
/* Host model: frames commands on the serial pins, msb first.
   Assumes i_mclk at 100 MHz; serial clock period is 16 i_mclk. */
`default_nettype none
module ssm_host (
	input  wire logic i_mclk,
	input  wire logic i_so,
	input  wire logic i_so_oe,
	input  wire logic i_hold_n,
	output var  logic o_cs_n,
	output var  logic o_sck,
	output var  logic o_si
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        mode3 = 1'b0;
	logic [15:0] rx    = 16'h0;
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_si   = 1'b0;
	end
	// ====================
	// Frame of n bits
	task automatic op(input logic [47:0] d, input int n);
		@(posedge i_mclk);
		o_sck <= mode3;
		repeat (8) @(posedge i_mclk);
		o_cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge i_mclk);
			while (!i_hold_n) repeat (8) @(posedge i_mclk);
			o_sck <= 1'b0;
			o_si  <= d[47 - i];
			repeat (8) @(posedge i_mclk);
			o_sck <= 1'b1;
			rx    <= {rx[14:0], i_so_oe ? i_so : ~rx[0]};
			repeat (4) @(posedge i_mclk);
			o_si  <= ~d[47 - i];
		end
		repeat (8) @(posedge i_mclk);
		o_sck  <= mode3;
		o_cs_n <= 1'b1;
		repeat (8) @(posedge i_mclk);
	endtask : op
endmodule : ssm_host
`default_nettype wire

// ===== test/ssm_slave_tb.sv
/* Self-checking bench for ssm_slave through the host model.
   Assumes ssm_host frames at a 160 ns serial clock. */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module ssm_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ssm_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_hold_n = 1'b1;
	logic i_wp_n = 1'b1;
	logic i_ce = 1'b1;
	logic cs_n, sck, si, so, so_oe, standby, sleep;
	int   n_fail = 0;
	int   cmp_count = 0;
	int   cyc = 0;
	always #5 i_mclk = ~i_mclk;
	ssm_slave i_ssm_slave (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_cs_n(cs_n),
		.i_sck(sck), .i_si(si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(so),
		.o_so_oe(so_oe), .o_standby(standby), .o_sleep(sleep));
	ssm_host i_ssm_host (.i_mclk(i_mclk), .i_so(so), .i_so_oe(so_oe),
		.i_hold_n(i_hold_n), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
	// ====================
	// Tasks
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic q(input logic [47:0] d, input int n, input logic [7:0] e);
		i_ssm_host.op(d, n);
		`CHK(i_ssm_host.rx[7:0], e)
	endtask : q
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_mclk);
		`CHK(standby, 1'b1)
		q({SSM_OP_STAT_RD, 40'h0}, 16, SSM_SR_RST);
		i_ssm_host.op({SSM_OP_STAT_WR, 8'h8c, 32'h0}, 16);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h00);
		i_ssm_host.op({SSM_OP_SET_WE, 40'h0}, 8);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h02);
		i_ssm_host.op({SSM_OP_CLR_WE, 40'h0}, 8);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h00);
		i_ssm_host.op({SSM_OP_SET_WE, SSM_OP_CLR_WE, 32'h0}, 16);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h02);
		$display("test latch done");
		i_ssm_host.mode3 = 1'b1;
		i_ssm_host.op({SSM_OP_MEM_WR, 24'h01ffff, 16'ha53c}, 48);
		i_ssm_host.op({SSM_OP_MEM_WR, 24'h0, 16'h0}, 36);
		q({SSM_OP_MEM_RD, 24'h01ffff, 16'h0}, 40, 8'ha5);
		i_ssm_host.mode3 = 1'b0;
		q({SSM_OP_MEM_RD, 24'hfe0000, 16'h0}, 40, 8'h3c);
		$display("test memory done");
		i_ssm_host.op({SSM_OP_STAT_WR, 8'h8c, 32'h0}, 16);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h8e);
		i_ssm_host.op({SSM_OP_MEM_WR, 24'h0, 16'h1100}, 40);
		q({SSM_OP_MEM_RD, 24'h0, 16'h0}, 40, 8'h3c);
		i_wp_n <= 1'b0;
		i_ssm_host.op({SSM_OP_STAT_WR, 40'h0}, 16);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h8e);
		i_wp_n <= 1'b1;
		i_ssm_host.op({SSM_OP_STAT_WR, 8'h04, 32'h0}, 16);
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h06);
		i_ssm_host.op({SSM_OP_MEM_WR, 24'h01ffff, 16'h7766}, 48);
		fork
			i_ssm_host.op({SSM_OP_MEM_RD, 24'h01ffff, 16'h0}, 48);
			begin
				repeat (599) @(posedge i_mclk);
				i_hold_n <= 1'b0;
				repeat (10) @(posedge i_mclk);
				`CHK(so_oe, 1'b0)
				repeat (20) @(posedge i_mclk);
				i_hold_n <= 1'b1;
			end
		join
		`CHK(i_ssm_host.rx, 16'ha566)
		$display("test protect done");
		i_ssm_host.op({SSM_OP_SLEEP, 40'h0}, 8);
		`CHK(sleep, 1'b1)
		i_ssm_host.op({SSM_OP_CLR_WE, 40'h0}, 8);
		i_ssm_host.op({SSM_OP_WAKE, 40'h0}, 8);
		`CHK(sleep, 1'b0)
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h06);
		$display("test sleep done");
		i_ce <= 1'b0;
		i_ssm_host.op({SSM_OP_SLEEP, 40'h0}, 8);
		`CHK(sleep, 1'b0)
		`CHK(standby, 1'b1)
		i_ce <= 1'b1;
		q({SSM_OP_STAT_RD, 40'h0}, 16, 8'h06);
		$display("test enable done");
		conclude();
	end
endmodule : ssm_slave_tb
`default_nettype wire
